// file: dhb_pkg.sv
// constants and types shared by the converter host-bus controller
package dhb_pkg;

    // clock and pin timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CLR_MIN_NS    = 100; // clear low time, full temperature range
    localparam int unsigned CLR_CYC       = (CLR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CS_LOW_NS     = 110; // select low time for a load
    localparam int unsigned CS_LOW_CYC    = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RD_VALID_NS   = 180; // select low to readback data valid
    localparam int unsigned RD_VALID_CYC  = (RD_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_NS       = 15;  // data and address hold after select
    localparam int unsigned HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POR_CYC_DEF   = 16;
    localparam int unsigned CNT_W         = 3;

    // host i/o page and offsets inside it
    localparam logic [9:0] PAGE_BASE     = 10'h300;
    localparam logic [9:0] PAGE_LAST     = 10'h31f;
    localparam logic [9:0] PIN_ADDR_IDLE = 10'h318;
    localparam logic [4:0] OFF_DAC_FIRST = 5'h10;
    localparam logic [4:0] OFF_XFER      = 5'h18;
    localparam int unsigned LS_BIT       = 3;
    localparam int unsigned MS_BIT       = 4;

    // software register offsets
    localparam logic [7:0] REG_ADDR   = 8'h00;
    localparam logic [7:0] REG_WDATA  = 8'h04;
    localparam logic [7:0] REG_CMD    = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;

    // field positions
    localparam int unsigned ADDR_DEV_LSB = 10;
    localparam int unsigned CMD_CLR_BIT  = 4;
    localparam int unsigned ST_BUSY_BIT  = 0;
    localparam int unsigned ST_ILL_BIT   = 1;
    localparam int unsigned ST_OVR_BIT   = 2;

    typedef enum logic [1:0] {OP_WR, OP_RD, OP_WR12, OP_RD12} dhb_op_t;

    typedef struct packed {
        logic [9:0] addr;
        logic       rd;
        logic [7:0] data;
        logic       last;
    } dhb_step_t;

    // host address falls inside the converter page
    function automatic logic page_hit(input logic [9:0] a);
        page_hit = (a >= PAGE_BASE) && (a <= PAGE_LAST);
    endfunction

    // even offsets below the second mode rank must never be used
    function automatic logic offset_illegal(input logic [4:0] off);
        offset_illegal = (off[4:3] == 2'b00) && !off[0];
    endfunction

endpackage

// file: dhb_clear_gen.sv
// power-on clear stretcher merged with the software clear request
`timescale 1ns/1ps
`default_nettype none
module dhb_clear_gen
    import dhb_pkg::*;
#(
    parameter int unsigned POR_CYC = POR_CYC_DEF
) (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_arst_n,
    input  wire logic i_ce,
    // request and pin
    input  wire logic i_sw_clear,
    output var  logic o_clear_n
);

    initial begin
        if (POR_CYC < CLR_CYC || POR_CYC > 65535) begin
            $error("dhb_clear_gen: POR_CYC out of range");
        end
    end

    typedef struct packed {
        logic [15:0]      por_cnt;
        logic [CNT_W-1:0] clr_cnt;
        logic             clear_n;
    } dhb_clr_state_t;

    localparam dhb_clr_state_t RST_VAL = '{por_cnt: 16'(POR_CYC), clr_cnt: '0, clear_n: 1'b0};

    dhb_clr_state_t q;
    dhb_clr_state_t d;

    // count down both sources, either one holds the pin low
    always_comb begin
        d = q;
        if (q.por_cnt != 16'h0000) begin
            d.por_cnt = q.por_cnt - 16'h0001; // RQ3
        end
        if (i_sw_clear) begin
            d.clr_cnt = CNT_W'(CLR_CYC); // RQ2
        end else if (q.clr_cnt != '0) begin
            d.clr_cnt = q.clr_cnt - CNT_W'(1);
        end
        d.clear_n = (d.por_cnt == 16'h0000) && (d.clr_cnt == '0); // RQ4
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= RST_VAL;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_clear_n = q.clear_n;

endmodule
`default_nettype wire

// file: dhb_dev_decode.sv
// page decode and 1-of-n converter select, gated by the i/o strobe
`timescale 1ns/1ps
`default_nettype none
module dhb_dev_decode
    import dhb_pkg::*;
#(
    parameter int unsigned NDEV = 8
) (
    // clock and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_arst_n,
    input  wire logic            i_ce,
    // next cycle strobe and address
    input  wire logic            i_strobe,
    input  wire logic [9:0]      i_addr,
    input  wire logic [2:0]      i_dev,
    // selects
    output var  logic            o_cs_n,
    output var  logic [NDEV-1:0] o_dev_cs_n
);

    initial begin
        if (NDEV < 1 || NDEV > 8) begin
            $error("dhb_dev_decode: NDEV must be 1 to 8");
        end
    end

    typedef struct packed {
        logic            cs_n;
        logic [NDEV-1:0] dev_cs_n;
    } dhb_dec_state_t;

    dhb_dec_state_t q;
    dhb_dec_state_t d;
    logic [NDEV-1:0] dev_hit;

    // one select line per converter
    for (genvar g = 0; g < NDEV; g++) begin : g_dev
        assign dev_hit[g] = i_strobe && (i_dev == 3'(g)); // RQ14
    end

    // selects only while the strobe is active
    always_comb begin
        d          = q;
        d.cs_n     = !(i_strobe && page_hit(i_addr)); // RQ5 RQ18
        d.dev_cs_n = ~dev_hit;
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '1;
        end else if (i_ce) begin
            q <= d;
        end
    end

    assign o_cs_n     = q.cs_n;
    assign o_dev_cs_n = q.dev_cs_n;

endmodule
`default_nettype wire

// file: dhb_host_ctrl.sv
// host-side bus controller for a quad 12-bit converter with a parallel port
// What this block does
// [RQ1] on clear, the small-package converter keeps mode and returns outputs to zero
// [RQ2] clear input is held low at least 100 ns
// [RQ3] a power-on clear drives the clear input after start-up
// [RQ4] power-on clear and software clear are merged, either asserts it
// [RQ5] page select is active for host addresses 300 to 31f hex only
// [RQ6] address bits 2..0 drive quad/channel, bit 3 rank load, bit 4 mode select
// [RQ7] a 12-bit write is low nibble, high byte, then second-rank transfer
// [RQ8] a 12-bit readback is two reads, eight msbs then four lsbs
// [RQ9] even offsets 300 to 306 are refused; odd ones reach mode first rank
// [RQ10] offsets 308 to 30f select the mode second rank
// [RQ11] from 310 each channel has an even low-nibble and odd high-byte address
// [RQ12] transparent enable is held high since the bus is only 8 bits
// [RQ13] low address bits pick registers, select is strobe gated by bus phase
// [RQ14] a 1-of-8 decode on the device index picks one converter
// [RQ15] read, mode, clear and rank-load lines are driven by this controller
// [RQ16] unused clear or mode lines may be tied high by the system
// [RQ17] a pin cycle of 250 ns (300 ns for a read) is shorter than a 1.5 MHz host bus cycle
// [RQ18] select is active only while strobe and address are stable
// [RQ19] on clear, large-package converters go to unipolar 10 v gain one, codes zero
// [RQ20] offsets 318 to 31f transfer to second rank; 316, 317 load channel d
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dhb_host_ctrl
    import dhb_pkg::*;
#(
    parameter int unsigned NDEV    = 8,
    parameter int unsigned POR_CYC = POR_CYC_DEF
) (
    // clock, reset, enable
    input  wire logic            i_ref_clk,
    input  wire logic            i_arst_n,
    input  wire logic            i_ce,
    // software register port
    input  wire logic [7:0]      i_bus_addr,
    input  wire logic [31:0]     i_bus_wdata,
    input  wire logic            i_bus_wr,
    input  wire logic            i_bus_rd,
    output var  logic [31:0]     o_bus_rdata,
    // converter address and control pins
    output var  logic [9:0]      o_host_addr,
    output var  logic [2:0]      o_quad_chan_sel,
    output var  logic            o_rank_load_strobe_n,
    output var  logic            o_mode_register_select_n,
    output var  logic            o_transparent_enable_n,
    output var  logic            o_rd_n,
    output var  logic            o_cs_n,
    output var  logic [NDEV-1:0] o_dev_cs_n,
    output var  logic            o_clear_n,
    // converter data pins
    input  wire logic [7:0]      i_data,
    output var  logic [7:0]      o_data,
    output var  logic            o_data_oe
);

    initial begin
        if (CS_LOW_CYC >= (1 << CNT_W) || RD_VALID_CYC >= (1 << CNT_W)) begin
            $error("dhb_host_ctrl: counter too narrow for pin timing");
        end
    end

    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} dhb_state_t;

    typedef struct packed {
        dhb_state_t       st;
        logic [1:0]       step;
        logic [CNT_W-1:0] cnt;
        dhb_op_t          op;
        logic [9:0]       addr;
        logic [2:0]       dev;
        logic [11:0]      wdata;
        logic [11:0]      rdata;
        logic             ill;
        logic             ovr;
        logic             clr_req;
        logic [31:0]      bus_rdata;
        logic [9:0]       pin_addr;
        logic             rd_n;
        logic [7:0]       dout;
        logic             oe;
        logic             strobe;
        logic             te_n;
    } dhb_ctrl_state_t;

    localparam dhb_ctrl_state_t RST_VAL = '{
        st: S_IDLE, step: 2'd0, cnt: '0, op: OP_WR, addr: PAGE_BASE, dev: 3'd0,
        wdata: 12'h000, rdata: 12'h000, ill: 1'b0, ovr: 1'b0, clr_req: 1'b0,
        bus_rdata: 32'h0000_0000, pin_addr: PIN_ADDR_IDLE, rd_n: 1'b1, // RQ16
        dout: 8'h00, oe: 1'b0, strobe: 1'b0, te_n: 1'b1
    };

    dhb_ctrl_state_t q;
    dhb_ctrl_state_t d;
    dhb_step_t       plan;

    // address, direction and data of one pin cycle of an operation
    function automatic dhb_step_t step_plan(input dhb_op_t op, input logic [1:0] step,
                                            input logic [9:0] a, input logic [11:0] w);
        dhb_step_t s;
        logic [9:0] chan_lo;
        chan_lo = {a[9:5], OFF_DAC_FIRST | {2'b00, a[2:1], 1'b0}}; // RQ11 RQ20
        s.addr  = a;
        s.rd    = 1'b0;
        s.data  = w[7:0];
        s.last  = 1'b1;
        case (op)
            OP_RD: begin
                s.rd = 1'b1;
            end
            OP_WR12: begin
                s.last = (step == 2'd2); // RQ7
                case (step)
                    2'd0: begin
                        s.addr = chan_lo;
                        s.data = {4'h0, w[3:0]};
                    end
                    2'd1: begin
                        s.addr = chan_lo | 10'h001;
                        s.data = w[11:4];
                    end
                    default: begin
                        s.addr = {a[9:5], OFF_XFER}; // RQ20
                        s.data = 8'h00;
                    end
                endcase
            end
            OP_RD12: begin
                s.rd   = 1'b1;
                s.last = (step == 2'd1); // RQ8
                s.addr = (step == 2'd0) ? (chan_lo | 10'h001) : chan_lo;
            end
            default: begin
                s.rd = 1'b0;
            end
        endcase
        return s;
    endfunction

    assign plan = step_plan(q.op, q.step, q.addr, q.wdata);

    // register port, operation sequencer and pin drive
    always_comb begin
        d           = q;
        d.clr_req   = 1'b0;
        d.bus_rdata = 32'h0000_0000;

        // status write-one-to-clear first so a same-cycle set wins
        if (i_bus_wr && i_bus_addr == REG_STATUS) begin
            if (i_bus_wdata[ST_ILL_BIT]) begin
                d.ill = 1'b0;
            end
            if (i_bus_wdata[ST_OVR_BIT]) begin
                d.ovr = 1'b0;
            end
        end

        // software reads, data one cycle later
        if (i_bus_rd) begin
            case (i_bus_addr)
                REG_ADDR:   d.bus_rdata = {19'h00000, q.dev, q.addr};
                REG_WDATA:  d.bus_rdata = {20'h00000, q.wdata};
                REG_STATUS: d.bus_rdata = {29'h00000000, q.ovr, q.ill, q.st != S_IDLE};
                REG_RDATA:  d.bus_rdata = {20'h00000, q.rdata};
                default:    d.bus_rdata = 32'h0000_0000;
            endcase
        end

        // software writes to address, data and command refused while a pin cycle runs; the clear bit is taken at once
        if (i_bus_wr) begin
            if (i_bus_addr == REG_CMD && i_bus_wdata[CMD_CLR_BIT]) begin
                d.clr_req = 1'b1; // RQ4
            end
            if (i_bus_addr == REG_ADDR || i_bus_addr == REG_WDATA || i_bus_addr == REG_CMD) begin
                if (q.st != S_IDLE) begin
                    d.ovr = 1'b1;
                end else begin
                    case (i_bus_addr)
                        REG_ADDR: begin
                            d.addr = i_bus_wdata[9:0];
                            d.dev  = i_bus_wdata[ADDR_DEV_LSB +: 3];
                        end
                        REG_WDATA: begin
                            d.wdata = i_bus_wdata[11:0];
                        end
                        default: begin
                            d.op = dhb_op_t'(i_bus_wdata[1:0]);
                            if ((i_bus_wdata[1:0] == 2'(OP_WR) || i_bus_wdata[1:0] == 2'(OP_RD))
                                && offset_illegal(q.addr[4:0]) && !i_bus_wdata[CMD_CLR_BIT]) begin
                                d.ill = 1'b1; // RQ9
                            end else if (!i_bus_wdata[CMD_CLR_BIT]) begin
                                d.st   = S_SETUP;
                                d.step = 2'd0;
                            end
                        end
                    endcase
                end
            end
        end

        // pin cycle sequencer
        case (q.st)
            S_IDLE: begin
                d.strobe = 1'b0;
                d.oe     = 1'b0;
                d.rd_n   = 1'b1;
            end
            S_SETUP: begin
                // address, direction and strobe are set together, so the select falls in the same cycle as the address
                d.pin_addr = plan.addr; // RQ6 RQ10 RQ13
                d.rd_n     = !plan.rd; // RQ15
                d.dout     = plan.data;
                d.oe       = !plan.rd;
                d.strobe   = 1'b1; // RQ18
                d.cnt      = plan.rd ? CNT_W'(RD_VALID_CYC) : CNT_W'(CS_LOW_CYC); // RQ17
                d.st       = S_STROBE;
            end
            S_STROBE: begin
                if (q.cnt == CNT_W'(1)) begin
                    d.strobe = 1'b0;
                    d.cnt    = CNT_W'(HOLD_CYC);
                    d.st     = S_HOLD;
                    if (plan.rd) begin
                        case (q.op)
                            OP_RD12: begin
                                if (q.step == 2'd0) begin
                                    d.rdata[11:4] = i_data; // RQ8
                                end else begin
                                    d.rdata[3:0] = i_data[3:0];
                                end
                            end
                            default: d.rdata = {4'h0, i_data};
                        endcase
                    end
                end else begin
                    d.cnt = q.cnt - CNT_W'(1);
                end
            end
            S_HOLD: begin
                // address and data stay until the select has risen
                if (q.cnt == CNT_W'(1)) begin
                    d.rd_n = 1'b1; // RQ15
                    if (plan.last) begin
                        d.st     = S_IDLE;
                        d.oe     = 1'b0;
                        d.step   = 2'd0;
                    end else begin
                        d.step = q.step + 2'd1;
                        d.st   = S_SETUP;
                    end
                end else begin
                    d.cnt = q.cnt - CNT_W'(1);
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase

        d.te_n = 1'b1; // RQ12
    end

    // state register
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= RST_VAL;
        end else if (i_ce) begin
            q <= d;
        end
    end

    // select generation, registered in step with the pins
    dhb_dev_decode #(
        .NDEV (NDEV)
    ) u_decode (
        .i_ref_clk  (i_ref_clk),
        .i_arst_n   (i_arst_n),
        .i_ce       (i_ce),
        .i_strobe   (d.strobe),
        .i_addr     (d.pin_addr),
        .i_dev      (d.dev),
        .o_cs_n     (o_cs_n),
        .o_dev_cs_n (o_dev_cs_n)
    );

    // power-on and software clear of the converter
    dhb_clear_gen #(
        .POR_CYC (POR_CYC)
    ) u_clear (
        .i_ref_clk  (i_ref_clk),
        .i_arst_n   (i_arst_n),
        .i_ce       (i_ce),
        .i_sw_clear (q.clr_req),
        .o_clear_n  (o_clear_n)
    );

    // pin and port outputs
    assign o_bus_rdata              = q.bus_rdata;
    assign o_host_addr              = q.pin_addr;
    assign o_quad_chan_sel          = q.pin_addr[2:0];
    assign o_rank_load_strobe_n     = q.pin_addr[LS_BIT];
    assign o_mode_register_select_n = q.pin_addr[MS_BIT];
    assign o_transparent_enable_n   = q.te_n;
    assign o_rd_n                   = q.rd_n;
    assign o_data                   = q.dout;
    assign o_data_oe                = q.oe;

endmodule
`default_nettype wire

// file: dhb_host_ctrl_assertions.sv
// pin timing checker of the converter host-bus controller
`timescale 1ns/1ps
`default_nettype none
module dhb_host_ctrl_chk
    import dhb_pkg::*;
#(
    parameter int unsigned NDEV = 8
) (
    // clock and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_arst_n,
    // converter pins
    input  wire logic [9:0]      o_host_addr,
    input  wire logic [2:0]      o_quad_chan_sel,
    input  wire logic            o_rank_load_strobe_n,
    input  wire logic            o_mode_register_select_n,
    input  wire logic            o_transparent_enable_n,
    input  wire logic            o_rd_n,
    input  wire logic            o_cs_n,
    input  wire logic [NDEV-1:0] o_dev_cs_n,
    input  wire logic            o_clear_n,
    input  wire logic            o_data_oe
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    // page, address split, refused offsets and transparent enable
    chk_page_only: assert property (!o_cs_n |-> o_host_addr inside {[10'h300:10'h31f]})
        else $error("select outside the converter page");
    chk_addr_split: assert property (!o_cs_n |-> o_quad_chan_sel == o_host_addr[2:0]
        && o_rank_load_strobe_n == o_host_addr[3] && o_mode_register_select_n == o_host_addr[4])
        else $error("address bits not split onto select pins");
    chk_even_refused: assert property (!o_cs_n |-> !(o_host_addr[4:3] == 2'b00 && !o_host_addr[0]))
        else $error("select on an illegal even offset");
    chk_te_high: assert property (o_transparent_enable_n)
        else $error("transparent enable driven low");
    // select widths and holds, data direction, one device and clear width
    chk_write_width: assert property ($fell(o_cs_n) && o_rd_n |-> !o_cs_n [*3] ##1 o_cs_n)
        else $error("write select not three cycles");
    chk_read_width: assert property ($fell(o_cs_n) && !o_rd_n |-> !o_cs_n [*4] ##1 o_cs_n)
        else $error("read select not four cycles");
    chk_addr_hold: assert property ($past(!o_cs_n) |-> $stable(o_host_addr) && $stable(o_rd_n))
        else $error("address moved while selected");
    chk_dir_oe: assert property (!o_cs_n |-> o_data_oe == o_rd_n)
        else $error("data drive disagrees with direction");
    chk_rd_release: assert property ($rose(o_cs_n) && !o_rd_n |=> o_rd_n)
        else $error("read direction not released after select");
    chk_one_device: assert property (!o_cs_n |-> $onehot(~o_dev_cs_n))
        else $error("not exactly one device selected");
    chk_clear_width: assert property ($fell(o_clear_n) |=> !o_clear_n)
        else $error("clear pulse shorter than two cycles");

    // main scenarios
    cov_write: cover property ($fell(o_cs_n) && o_rd_n);
    cov_read: cover property ($fell(o_cs_n) && !o_rd_n);
    cov_clear: cover property ($fell(o_clear_n));
endmodule

bind dhb_host_ctrl dhb_host_ctrl_chk #(.NDEV(NDEV)) u_chk (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .o_host_addr(o_host_addr),
    .o_quad_chan_sel(o_quad_chan_sel), .o_rank_load_strobe_n(o_rank_load_strobe_n),
    .o_mode_register_select_n(o_mode_register_select_n),
    .o_transparent_enable_n(o_transparent_enable_n), .o_rd_n(o_rd_n), .o_cs_n(o_cs_n),
    .o_dev_cs_n(o_dev_cs_n), .o_clear_n(o_clear_n), .o_data_oe(o_data_oe)
);
`default_nettype wire

// file: dhb_conv_model.sv
// behavioural model of the quad converter register port
`timescale 1ns/1ps
`default_nettype none
module dhb_conv_model #(
    parameter bit LARGE_PKG = 1'b0
) (
    // select and address pins
    input  wire logic       i_cs_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_clear_n,
    input  wire logic [2:0] i_quad_chan_sel,
    input  wire logic       i_rank_load_strobe_n,
    input  wire logic       i_mode_register_select_n,
    // data port
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data
);
    logic [7:0]  mode1 [4];
    logic [7:0]  mode2;
    logic [11:0] rank1 [4];
    logic [11:0] rank2 [4];
    logic [7:0]  last_q = 8'h00;
    logic [7:0]  rd_val;
    logic [4:0]  off;

    assign off = {i_mode_register_select_n, i_rank_load_strobe_n, i_quad_chan_sel};
    // readback value by offset
    always_comb begin
        rd_val = 8'h00;
        if (off[4:3] == 2'b10) begin
            rd_val = off[0] ? rank1[off[2:1]][11:4] : {4'h0, rank1[off[2:1]][3:0]};
        end else if (off[4:3] == 2'b01) begin
            rd_val = mode2;
        end else if (off[4:3] == 2'b11) begin
            rd_val = rank2[0][11:4];
        end
    end
    // released bus shows the inverse of the last value
    assign o_data = (!i_cs_n && !i_rd_n) ? rd_val : ~last_q;
    always @(posedge i_cs_n) if (!i_rd_n) last_q <= rd_val;
    // loads on select rising, clear wipes the codes
    always @(posedge i_cs_n or negedge i_clear_n) begin
        if (!i_clear_n) begin
            for (int c = 0; c < 4; c++) begin
                rank1[c] <= 12'h000;
                rank2[c] <= 12'h000;
                if (LARGE_PKG) mode1[c] <= 8'h00;
            end
            if (LARGE_PKG) mode2 <= 8'h00;
        end else if (i_rd_n) begin
            case (off[4:3])
                2'b00: if (off[0]) mode1[off[2:1]] <= i_data;
                2'b01: mode2 <= i_data;
                2'b10: if (off[0]) rank1[off[2:1]][11:4] <= i_data;
                       else rank1[off[2:1]][3:0] <= i_data[3:0];
                default: for (int c = 0; c < 4; c++) rank2[c] <= rank1[c];
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb.sv
// self-checking testbench of the converter host-bus controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dhb_pkg::*;
    localparam int unsigned PORC = 4;
    logic        clk = 1'b0;
    logic        arst_n, bus_wr, bus_rd, ls_n, ms_n, te_n, rd_n, cs_n, clear_n, oe;
    logic [7:0]  bus_addr, dev_cs_n, dut_data, mdl_data, bus_data, last_dev;
    logic [31:0] bus_wdata, bus_rdata, st;
    logic [9:0]  host_addr;
    logic [2:0]  qcs;
    logic [11:0] w;
    int          fail_count = 0;
    int          checks = 0;
    int          cs_falls = 0, clr_cnt = 0, n;

    dhb_host_ctrl #(.NDEV(8), .POR_CYC(PORC)) dut (
        .i_ref_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1), .i_bus_addr(bus_addr),
        .i_bus_wdata(bus_wdata), .i_bus_wr(bus_wr), .i_bus_rd(bus_rd), .o_bus_rdata(bus_rdata),
        .o_host_addr(host_addr), .o_quad_chan_sel(qcs), .o_rank_load_strobe_n(ls_n),
        .o_mode_register_select_n(ms_n), .o_transparent_enable_n(te_n), .o_rd_n(rd_n),
        .o_cs_n(cs_n), .o_dev_cs_n(dev_cs_n), .o_clear_n(clear_n), .i_data(bus_data),
        .o_data(dut_data), .o_data_oe(oe));
    dhb_conv_model model (
        .i_cs_n(cs_n), .i_rd_n(rd_n), .i_clear_n(clear_n), .i_quad_chan_sel(qcs),
        .i_rank_load_strobe_n(ls_n), .i_mode_register_select_n(ms_n), .i_data(bus_data),
        .o_data(mdl_data));
    // shared data wire resolved from the controller's enable
    assign bus_data = oe ? dut_data : mdl_data;

    // clock and pin observers
    always #25 clk = ~clk;
    always @(negedge cs_n) cs_falls++;
    always @(posedge clk) begin
        if (!cs_n) last_dev <= ~dev_cs_n;
        if (!clear_n) clr_cnt++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    // command, then poll busy with a bound
    task automatic cmd(input logic [31:0] c);
        logic [31:0] s;
        reg_wr(REG_CMD, c);
        for (int i = 0; i < 40; i++) begin
            reg_rd(REG_STATUS, s);
            if (s[ST_BUSY_BIT] === 1'b0) return;
        end
        $display("[FAIL] %0t busy never dropped", $time);
        fail_count++;
    endtask
    task automatic complete_run;
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #2000000;
        fail_count++;
        complete_run();
    end

    // main sequence
    initial begin
        arst_n = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        #1 check(32'(host_addr), 32'h318);
        check(32'(te_n), 32'h1);
        repeat (PORC - 1) @(posedge clk);
        #1 check(32'(clear_n), 32'h0);
        @(posedge clk);
        #1 check(32'(clear_n), 32'h1);
        reg_rd(REG_ADDR, st);
        check(st, 32'h300);
        reg_rd(8'h20, st);
        check(st, 32'h0);
        // even offsets refused for byte write and read
        for (int k = 0; k < 8; k++) begin
            n = cs_falls;
            reg_wr(REG_ADDR, 32'(10'h300 + 2 * (k >> 1)));
            cmd(32'(k & 1));
            reg_rd(REG_STATUS, st);
            check(st & 32'h7, 32'h2);
            check(32'(cs_falls - n), 32'h0);
            reg_wr(REG_STATUS, 32'h2);
        end
        // mode first rank on device five, second rank on device zero
        reg_wr(REG_ADDR, 32'h1705);
        reg_wr(REG_WDATA, 32'h5a);
        cmd(32'h0);
        check(32'(model.mode1[2]), 32'h5a);
        check(32'(last_dev), 32'h20);
        reg_wr(REG_ADDR, 32'h309);
        reg_wr(REG_WDATA, 32'ha5);
        cmd(32'h0);
        cmd(32'h1);
        reg_rd(REG_RDATA, st);
        check(st, 32'ha5);
        // twelve-bit codes on every channel
        for (int ch = 0; ch < 4; ch++) begin
            w = 12'h9c3 ^ 12'(ch * 12'h111);
            reg_wr(REG_ADDR, 32'(10'h300 + 2 * ch));
            reg_wr(REG_WDATA, 32'(w));
            cmd(32'h2);
            check(32'(model.rank2[ch]), 32'(w));
            cmd(32'h3);
            reg_rd(REG_RDATA, st);
            check(st, 32'(w));
        end
        // addresses just outside the page
        n = cs_falls;
        reg_wr(REG_ADDR, 32'h321);
        cmd(32'h0);
        reg_wr(REG_ADDR, 32'h2ff);
        cmd(32'h0);
        check(32'(cs_falls - n), 32'h0);
        // command while busy is refused
        reg_wr(REG_ADDR, 32'h302);
        reg_wr(REG_CMD, 32'h2);
        cmd(32'h2);
        reg_rd(REG_STATUS, st);
        check(st & 32'h4, 32'h4);
        reg_wr(REG_STATUS, 32'h6);
        // software clear pulse
        n = clr_cnt;
        cmd(32'h10);
        repeat (4) @(posedge clk);
        check(32'(clr_cnt - n), 32'(CLR_CYC));
        check(32'(model.rank2[0]), 32'h0);
        check(32'(model.mode1[2]), 32'h5a);
        cmd(32'h3);
        reg_rd(REG_RDATA, st);
        check(st, 32'h0);
        reg_rd(REG_STATUS, st);
        check(st, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
